// >>> ebt3_timer.sv
// timer three control block with wishbone register access
//
// Functional notes
// - control, period and pulse-width registers steer timer
// - clock select codes pick prescaler taps
// - low speed states allow three clocks only
// - mode field picks four modes, 1xx reserved
// - cascade needs mode 011, timer four mode
// - cascade uses own clock, four's run/level
//
// Added by the designer: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "ebt3_regs.svh"

module ebt3_timer
  import ebt3_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [ADDR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // clock pins
  input wire logic i_low_freq_clock,
  input wire logic i_timer_pin,
  // timer outputs
  output logic o_flipflop,
  output logic o_match,
  output logic [15:0] o_count
);

  // ----------------------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------------------
  // the register map reaches offset 0x14, so five address bits are the least
  if (ADDR_W < 5) begin : g_addr_w_check
    $error("ADDR_W too small for register map");
  end
  if (`EBT3_PRESCALE_W < `EBT3_TAP_11) begin : g_prescale_check
    $error("prescaler narrower than the slowest tap");
  end

  // ----------------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------------
  logic rst_s1_reg;
  logic rst_n_reg;
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg <= rst_s1_reg;
    end
  end

  // ----------------------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------------------
  // two stages settle the pin; the third only keeps the last level for edges
  logic [2:0] lf_sync_reg;
  logic [2:0] pin_sync_reg;
  always_ff @(posedge i_core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      lf_sync_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
    end else begin
      lf_sync_reg <= {lf_sync_reg[1:0], i_low_freq_clock};
      pin_sync_reg <= {pin_sync_reg[1:0], i_timer_pin};
    end
  end
  logic lf_edge;
  logic pin_edge;
  assign lf_edge = lf_sync_reg[1] & ~lf_sync_reg[2];
  assign pin_edge = pin_sync_reg[1] & ~pin_sync_reg[2];

  // ----------------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------------
  ebt3_ctl_t ctl_reg;
  logic [7:0] period_reg;
  logic [7:0] pulse_width_reg;
  ebt3_ctl_t t4_ctl_reg;
  logic [7:0] t4_period_reg;
  logic [1:0] config_reg;

  logic bus_req;
  logic wr_en;
  logic [ADDR_W-1:0] adr;
  assign bus_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wr_en = bus_req & i_wb_we;
  assign adr = i_wb_adr;

  // software keeps period, pulse width and fields stable while running; the
  // registers themselves accept any write so a misuse only mistimes the output
  always_ff @(posedge i_core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ctl_reg <= `EBT3_RST_CONTROL;
      period_reg <= `EBT3_RST_PERIOD;
      pulse_width_reg <= `EBT3_RST_PULSE_WIDTH;
      {t4_period_reg, t4_ctl_reg} <= `EBT3_RST_T4_CONTROL;
      config_reg <= `EBT3_RST_CONFIG;
    end else if (wr_en) begin
      if (adr == ADDR_W'(`EBT3_OFF_CONTROL) && i_wb_sel[0]) begin
        ctl_reg <= i_wb_dat[7:0];
      end
      if (adr == ADDR_W'(`EBT3_OFF_PERIOD) && i_wb_sel[0]) begin
        period_reg <= i_wb_dat[7:0];
      end
      if (adr == ADDR_W'(`EBT3_OFF_PULSE_WIDTH) && i_wb_sel[0]) begin
        pulse_width_reg <= i_wb_dat[7:0];
      end
      if (adr == ADDR_W'(`EBT3_OFF_T4_CONTROL)) begin
        if (i_wb_sel[0]) begin
          t4_ctl_reg <= i_wb_dat[7:0];
        end
        if (i_wb_sel[1]) begin
          t4_period_reg <= i_wb_dat[15:8];
        end
      end
      if (adr == ADDR_W'(`EBT3_OFF_CONFIG) && i_wb_sel[0]) begin
        config_reg <= i_wb_dat[1:0];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // effective control, cascade routing
  // ----------------------------------------------------------------------------
  logic cascade;
  logic run_eff;
  logic level_eff;
  logic [2:0] mode_eff;
  logic mode_ok;
  assign cascade = (ctl_reg.mode_select == EBT3_MODE_CASCADE);
  assign mode_eff = cascade ? t4_ctl_reg.mode_select : ctl_reg.mode_select;
  assign run_eff = cascade ? t4_ctl_reg.run : ctl_reg.run;
  assign level_eff = cascade ? t4_ctl_reg.ff_level : ctl_reg.ff_level;
  // cascade keeps timer three's own field at 011, so this check stays valid
  assign mode_ok = ~ctl_reg.mode_select[2];

  // ----------------------------------------------------------------------------
  // prescaler and source clock selection
  // ----------------------------------------------------------------------------
  // the prescaler runs free, so the first tick after a start may come early
  logic [`EBT3_PRESCALE_W-1:0] pre_reg;
  logic [`EBT3_LF_DIV_W-1:0] lf_div_reg;
  always_ff @(posedge i_core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pre_reg <= '0;
      lf_div_reg <= '0;
    end else begin
      pre_reg <= pre_reg + 1'b1;
      if (lf_edge) begin
        lf_div_reg <= lf_div_reg + 1'b1;
      end
    end
  end

  logic tap11;
  logic tap7;
  logic tap5;
  logic tap3;
  logic tap1;
  logic lf_div_tick;
  assign tap11 = &pre_reg[`EBT3_TAP_11-1:0];
  assign tap7 = &pre_reg[`EBT3_TAP_7-1:0];
  assign tap5 = &pre_reg[`EBT3_TAP_5-1:0];
  assign tap3 = &pre_reg[`EBT3_TAP_3-1:0];
  assign tap1 = &pre_reg[`EBT3_TAP_1-1:0];
  assign lf_div_tick = lf_edge & (&lf_div_reg);

  logic tick;
  always_comb begin
    tick = 1'b0;
    if (config_reg[`EBT3_CFG_SLOW_BIT]) begin
      // only the low clock taps and the full clock (warm-up) exist here
      unique case (ebt3_clk_t'(ctl_reg.clock_select))
        EBT3_CLK_SLOWEST: tick = lf_div_tick;
        EBT3_CLK_LOW: tick = lf_edge;
        EBT3_CLK_FULL: tick = 1'b1;
        default: tick = 1'b0;
      endcase
    end else begin
      unique case (ebt3_clk_t'(ctl_reg.clock_select))
        EBT3_CLK_SLOWEST: tick = config_reg[`EBT3_CFG_TAP_BIT] ? lf_div_tick : tap11;
        EBT3_CLK_DIV7: tick = tap7;
        EBT3_CLK_DIV5: tick = tap5;
        EBT3_CLK_DIV3: tick = tap3;
        EBT3_CLK_LOW: tick = lf_edge;
        EBT3_CLK_DIV1: tick = tap1;
        EBT3_CLK_FULL: tick = 1'b1;
        EBT3_CLK_PIN: tick = pin_edge;
      endcase
    end
  end

  // reserved codes in timer three's own mode field park the counter rather than guess a mode
  logic count_en;
  assign count_en = tick & mode_ok;

  // ----------------------------------------------------------------------------
  // counter and flip-flop
  // ----------------------------------------------------------------------------
  logic run_d_reg;
  logic [15:0] count_reg;
  logic [15:0] limit;
  logic at_limit;
  assign limit = cascade ? {t4_period_reg, period_reg} : {8'h00, period_reg};
  // a period of zero matches on every tick
  assign at_limit = (count_reg == limit);

  always_ff @(posedge i_core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      run_d_reg <= 1'b0;
      count_reg <= 16'h0000;
      o_match <= 1'b0;
    end else begin
      run_d_reg <= run_eff;
      o_match <= 1'b0;
      if (!run_eff) begin
        count_reg <= 16'h0000;
      end else if (count_en) begin
        if (at_limit) begin
          count_reg <= 16'h0000;
          o_match <= 1'b1;
        end else begin
          count_reg <= count_reg + 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // start detection
  // ----------------------------------------------------------------------------
  // level and start may come in one write, so the level is loaded again in the
  // first running cycle; a toggle due in that very cycle (period zero) is lost
  logic start_pulse;
  assign start_pulse = run_eff & ~run_d_reg;

  // level is loaded while stopped so the start sees the programmed value
  always_ff @(posedge i_core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      o_flipflop <= 1'b0;
    end else if (!run_eff || start_pulse) begin
      o_flipflop <= level_eff;
    end else if (count_en) begin
      if (mode_eff == EBT3_MODE_DIVIDER && at_limit) begin
        o_flipflop <= ~o_flipflop;
      end else if (mode_eff == EBT3_MODE_PWM && count_reg[7:0] == pulse_width_reg) begin
        o_flipflop <= ~o_flipflop;
      end else if (mode_eff == EBT3_MODE_PWM && at_limit) begin
        o_flipflop <= level_eff;
      end
    end
  end

  assign o_count = count_reg;

  // ----------------------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------------------
  // ack is registered, so a strobe held through ack is not taken twice
  logic [31:0] rd_data;
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (adr)
      ADDR_W'(`EBT3_OFF_CONTROL): rd_data = {24'h000000, ctl_reg};
      ADDR_W'(`EBT3_OFF_PERIOD): rd_data = {24'h000000, period_reg};
      ADDR_W'(`EBT3_OFF_PULSE_WIDTH): rd_data = {24'h000000, pulse_width_reg};
      ADDR_W'(`EBT3_OFF_T4_CONTROL): rd_data = {16'h0000, t4_period_reg, t4_ctl_reg};
      ADDR_W'(`EBT3_OFF_STATUS): rd_data = {14'h0000, run_d_reg, o_flipflop, count_reg};
      ADDR_W'(`EBT3_OFF_CONFIG): rd_data = {30'h00000000, config_reg};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= bus_req;
      if (bus_req && !i_wb_we) begin
        o_wb_dat <= rd_data;
      end
    end
  end

endmodule

// >>> ebt3_regs.svh
// register offsets, field positions, reset values and prescaler taps of timer three
`ifndef EBT3_REGS_SVH
`define EBT3_REGS_SVH

// ----------------------------------------------------------------------------
// byte offsets on the wishbone bus
// ----------------------------------------------------------------------------
`define EBT3_OFF_CONTROL 8'h00
`define EBT3_OFF_PERIOD 8'h04
`define EBT3_OFF_PULSE_WIDTH 8'h08
`define EBT3_OFF_T4_CONTROL 8'h0C
`define EBT3_OFF_STATUS 8'h10
`define EBT3_OFF_CONFIG 8'h14

// ----------------------------------------------------------------------------
// control field positions (same layout for timer four control byte) and config register bits
// ----------------------------------------------------------------------------
`define EBT3_FF_BIT 7
`define EBT3_CLK_MSB 6
`define EBT3_CLK_LSB 4
`define EBT3_RUN_BIT 3
`define EBT3_MODE_MSB 2
`define EBT3_MODE_LSB 0
`define EBT3_CFG_TAP_BIT 0
`define EBT3_CFG_SLOW_BIT 1

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define EBT3_RST_CONTROL 8'h00
`define EBT3_RST_PERIOD 8'hFF
`define EBT3_RST_PULSE_WIDTH 8'hFF
`define EBT3_RST_T4_CONTROL 16'hFF00
`define EBT3_RST_CONFIG 2'h0

// ----------------------------------------------------------------------------
// prescaler taps as powers of two of the high frequency clock
// ----------------------------------------------------------------------------
`define EBT3_TAP_11 11
`define EBT3_TAP_7 7
`define EBT3_TAP_5 5
`define EBT3_TAP_3 3
`define EBT3_TAP_1 1
`define EBT3_PRESCALE_W 11
`define EBT3_LF_DIV_W 3

`endif

// >>> ebt3_pkg.sv
// types shared by timer three control logic
package ebt3_pkg;

  typedef enum logic [2:0] {
    EBT3_MODE_TIMER = 3'h0,
    EBT3_MODE_DIVIDER = 3'h1,
    EBT3_MODE_PWM = 3'h2,
    EBT3_MODE_CASCADE = 3'h3
  } ebt3_mode_t;

  typedef enum logic [2:0] {
    EBT3_CLK_SLOWEST = 3'h0,
    EBT3_CLK_DIV7 = 3'h1,
    EBT3_CLK_DIV5 = 3'h2,
    EBT3_CLK_DIV3 = 3'h3,
    EBT3_CLK_LOW = 3'h4,
    EBT3_CLK_DIV1 = 3'h5,
    EBT3_CLK_FULL = 3'h6,
    EBT3_CLK_PIN = 3'h7
  } ebt3_clk_t;

  // bit 7 down to bit 0 of the control byte
  typedef struct packed {
    logic ff_level;
    logic [2:0] clock_select;
    logic run;
    logic [2:0] mode_select;
  } ebt3_ctl_t;

endpackage

// >>> ebt3_timer_assertions.sv
// concurrent checks on the timer three ports
`timescale 1ns/1ps
`include "ebt3_regs.svh"
module ebt3_timer_chk #(
  parameter int ADDR_W = 8
) (
  // clock, reset and bus
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [ADDR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  // timer outputs
  input wire logic o_flipflop,
  input wire logic o_match,
  input wire logic [15:0] o_count
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  wire take = i_wb_cyc && i_wb_stb && !o_wb_ack;
  // cascade and reserved modes excluded: in cascade the run bit is not ours
  wire stop_wr = take && i_wb_we && i_wb_sel[0] && i_wb_adr == ADDR_W'(`EBT3_OFF_CONTROL)
    && !i_wb_dat[3] && !i_wb_dat[2] && i_wb_dat[1:0] != 2'h3;
  property p_ack_resp; take |=> o_wb_ack; endproperty
  property p_ack_only; !take |=> !o_wb_ack; endproperty
  property p_rd_hold; !(take && !i_wb_we) |=> $stable(o_wb_dat); endproperty
  property p_unmapped; take && !i_wb_we && i_wb_adr > ADDR_W'(`EBT3_OFF_CONFIG) |=> o_wb_dat == 32'h0; endproperty
  property p_stop_clr; stop_wr |-> ##2 o_count == 16'h0; endproperty
  property p_level; stop_wr |-> ##2 o_flipflop == $past(i_wb_dat[7], 2); endproperty
  property p_match_wrap; o_match |-> o_count == 16'h0; endproperty
  property p_step; o_count != $past(o_count) |-> o_count == $past(o_count) + 16'h1 || o_count == 16'h0; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("ack missing");
  a_ack_only: assert property (p_ack_only) else $error("ack without request");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_stop_clr: assert property (p_stop_clr) else $error("stop kept count");
  a_level: assert property (p_level) else $error("level not loaded");
  a_match_wrap: assert property (p_match_wrap) else $error("match without wrap");
  a_step: assert property (p_step) else $error("count jumped");
  c_stop: cover property (stop_wr);
  c_match: cover property (o_match);
  c_cascade: cover property (o_count[8]);
endmodule
bind ebt3_timer ebt3_timer_chk #(.ADDR_W(ADDR_W)) u_chk (.i_core_clk, .i_rst_n, .i_wb_cyc, .i_wb_stb,
  .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .o_flipflop, .o_match, .o_count);

// >>> tb_top.sv
// self-checking bench for timer three control
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, lfc = 1'b0, pin = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic ack, ff, match;
  logic [15:0] cnt;
  int miscompares = 0, checks_done = 0;
  ebt3_timer dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_low_freq_clock(lfc), .i_timer_pin(pin), .o_flipflop(ff), .o_match(match), .o_count(cnt));
  initial begin
    forever #4 clk = ~clk;
  end
  // ------
  // helpers
  // ------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // request held until ack is sampled, then released for at least one cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) miscompares++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wait_match(output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (match !== 1'b1 && n < 9000);
    if (match !== 1'b1) miscompares++;
  endtask
  task automatic pulses(input bit use_pin, input int n);
    repeat (n) begin
      @(posedge clk);
      if (use_pin) pin <= 1'b1;
      else lfc <= 1'b1;
      repeat (4) @(posedge clk);
      pin <= 1'b0;
      lfc <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  task automatic cnt_is(input logic [15:0] e);
    repeat (4) @(posedge clk);
    check("count", {16'h0, cnt}, {16'h0, e});
  endtask
  // ------
  // scenarios
  // ------
  task automatic t_regs;
    logic [7:0] offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h18};
    logic [31:0] exps [6] = '{32'h0, 32'hFF, 32'hFF, 32'hFF00, 32'h0, 32'h0};
    wb(1'b1, 8'h18, 32'h5A);
    foreach (offs[i]) begin
      wb(1'b0, offs[i], 32'h0);
      check("reset value", q, exps[i]);
    end
    $display("regs done");
  endtask
  task automatic t_run;
    int n;
    wb(1'b1, 8'h04, 32'h3);
    wb(1'b0, 8'h04, 32'h0);
    check("period", q, 32'h3);
    wb(1'b1, 8'h00, 32'hE8);
    wait_match(n);
    wait_match(n);
    check("match span", n, 32'd4);
    wb(1'b1, 8'h00, 32'hE0);
    cnt_is(16'h0);
    check("level", {31'h0, ff}, 32'h1);
    $display("run done");
  endtask
  task automatic t_codes;
    logic [2:0] codes [6] = '{3'h6, 3'h5, 3'h3, 3'h2, 3'h1, 3'h0};
    int divs [6] = '{1, 2, 8, 32, 128, 2048};
    int n;
    wb(1'b1, 8'h04, 32'h1);
    foreach (codes[i]) begin
      wb(1'b1, 8'h00, {24'h0, 1'b0, codes[i], 4'h8});
      wait_match(n);
      wait_match(n);
      check("tick span", n, 2 * divs[i]);
      wb(1'b1, 8'h00, {24'h0, 1'b0, codes[i], 4'h0});
    end
    check("level", {31'h0, ff}, 32'h0);
    $display("codes done");
  endtask
  task automatic t_outputs;
    int n;
    wb(1'b1, 8'h04, 32'h1);
    // level, clock, divider mode and start in one write
    wb(1'b1, 8'h00, 32'hE9);
    wait_match(n);
    check("divider level", {31'h0, ff}, 32'h0);
    wait_match(n);
    check("divider level", {31'h0, ff}, 32'h1);
    wb(1'b1, 8'h00, 32'hE1);
    wb(1'b1, 8'h04, 32'h3);
    wb(1'b1, 8'h08, 32'h1);
    wb(1'b1, 8'h00, 32'h6A);
    wait_match(n);
    check("pwm level", {31'h0, ff}, 32'h0);
    repeat (2) @(posedge clk);
    check("pwm level", {31'h0, ff}, 32'h1);
    wb(1'b1, 8'h00, 32'h62);
    $display("outputs done");
  endtask
  task automatic t_low;
    wb(1'b1, 8'h04, 32'hFF);
    wb(1'b1, 8'h00, 32'h48);
    pulses(1'b0, 5);
    cnt_is(16'h5);
    wb(1'b1, 8'h00, 32'h40);
    wb(1'b1, 8'h14, 32'h1);
    wb(1'b1, 8'h00, 32'h08);
    pulses(1'b0, 16);
    cnt_is(16'h2);
    wb(1'b1, 8'h00, 32'h00);
    wb(1'b1, 8'h14, 32'h2);
    wb(1'b1, 8'h00, 32'h58);
    cnt_is(16'h0);
    wb(1'b1, 8'h00, 32'h50);
    wb(1'b1, 8'h14, 32'h0);
    wb(1'b1, 8'h00, 32'h78);
    pulses(1'b1, 4);
    cnt_is(16'h4);
    wb(1'b1, 8'h00, 32'h70);
    $display("low clock done");
  endtask
  task automatic t_modes;
    int n;
    wb(1'b1, 8'h00, 32'h6C);
    cnt_is(16'h0);
    wb(1'b1, 8'h00, 32'h64);
    wb(1'b1, 8'h04, 32'h0);
    // own run bit left clear: cascade must start from the timer four byte
    wb(1'b1, 8'h00, 32'h63);
    wb(1'b1, 8'h0C, 32'h0108);
    wait_match(n);
    wait_match(n);
    check("cascade span", n, 32'd257);
    wb(1'b1, 8'h0C, 32'h0100);
    cnt_is(16'h0);
    $display("modes done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs;
    t_run;
    t_codes;
    t_outputs;
    t_low;
    t_modes;
    final_report;
  end
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    final_report;
  end
endmodule
